// *** bbd_consts.vh ***
// constants for the battery backup domain controller
// Contract
// - battery power-up sets flag, opens supply switch
// - on battery, sample battery voltage about once per second
// - battery brownout monitor off on main power
// - after reset flag missing battery voltage
// - supply switching automatic from main brownout
// - crystal divided to 1.024kHz or 1Hz tick
// - low drive default, optional high drive
// - failure monitor flags permanent or temporary stop
// - counter advances once per prescaled tick
// - two retained registers survive main loss
// - main brownout moves supply, enables battery monitor
// - inputs ignored during main power loss
// - tick stretched during supply switchover
// - main loss resets logic outside domain
// - domain keeps running through switchover
// - registers inaccessible without main power
// - failure needs at least 64 missed swings
// - access needs enable, except supervision flags and domain reset
// - select zero gives 1Hz, one gives 1.024kHz
// - domain reset one cycle clears config, ready
`ifndef BBD_CONSTS_VH
`define BBD_CONSTS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define BBD_CLK_PERIOD_NS 8
`define BBD_FAIL_SWINGS 64
`define BBD_DIV_1HZ 32768
`define BBD_DIV_1KHZ 32
`define BBD_STARTUP_SWINGS 1024
`define BBD_SAMPLE_TICKS 1
`define BBD_STRETCH_CYCLES 4
// fast ticks that make up one second for battery sampling
`define BBD_FAST_PER_SEC 1024
// fail timeout in system clocks: 64 swings at 32.768kHz, about 1.95ms
`define BBD_FAIL_NS 1953125
`define BBD_FAIL_CYCLES ((`BBD_FAIL_NS + `BBD_CLK_PERIOD_NS - 1) / `BBD_CLK_PERIOD_NS)
`endif

// *** bbd_ctrl.v ***
// battery backup domain controller: supervision, switching, crystal tick and counter
`timescale 1ns/1ps
`include "bbd_consts.vh"
`default_nettype none
module bbd_ctrl #(
   parameter FAIL_CYCLES = `BBD_FAIL_CYCLES,
   parameter DIV_1HZ = `BBD_DIV_1HZ,
   parameter DIV_1KHZ = `BBD_DIV_1KHZ,
   parameter STARTUP_SWINGS = `BBD_STARTUP_SWINGS
) (
   input wire I_CLK_SYS,
   input wire I_RESETN,
   input wire I_CE,
   input wire I_MAIN_BROWNOUT,
   input wire I_BAT_PRESENT,
   input wire I_BAT_LOW,
   input wire I_XTAL_CLK,
   input wire I_DOMAIN_RESET,
   input wire I_ACCESS_SET,
   input wire I_OSC_ENABLE_SET,
   input wire I_FAIL_MON_SET,
   input wire I_HIGH_DRIVE_WR,
   input wire I_HIGH_DRIVE,
   input wire I_TICK_SEL_WR,
   input wire I_TICK_SEL,
   input wire I_CLR_BAT_ABSENT,
   input wire I_CLR_BAT_BROWNOUT,
   input wire I_CLR_BAT_POWER_ON,
   input wire I_CLR_OSC_FAIL,
   input wire I_BACKUP_WR,
   input wire I_BACKUP_SEL,
   input wire [7:0] I_BACKUP_DATA,
   output reg O_ON_BATTERY,
   output reg O_SUPPLY_SWITCH_CLOSED,
   output reg O_BAT_MONITOR_EN,
   output reg O_BAT_SAMPLE,
   output reg O_MAIN_DOMAIN_RESET,
   output reg O_HIGH_DRIVE,
   output reg O_OSC_ENABLE,
   output reg O_FAIL_MON_EN,
   output reg O_TICK_SEL,
   output reg O_ACCESS_EN,
   output reg O_BAT_POWER_ON_FLAG,
   output reg O_BAT_BROWNOUT_FLAG,
   output reg O_BAT_ABSENT_FLAG,
   output reg O_OSC_READY_FLAG,
   output reg O_OSC_FAIL_FLAG,
   output reg O_TICK,
   output reg [31:0] O_COUNTER,
   output reg [7:0] O_BACKUP0,
   output reg [7:0] O_BACKUP1
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // saturating increment used by the swing counter
   function [15:0] sat_inc;
      input [15:0] v;
      begin
         sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
      end
   endfunction

   // ----------------------------------------
   // local counts
   // ----------------------------------------
   // kept as integers and cut by part-selects, so that no assignment
   // quietly narrows a 32-bit constant into a short register
   localparam integer STRETCH = `BBD_STRETCH_CYCLES;
   localparam integer FAST_LAST = `BBD_FAST_PER_SEC - 1;
   // boot step at which the battery pin has crossed both sync stages;
   // looking earlier would read the reset value of the synchroniser
   localparam [1:0] BOOT_SAMPLE = 2'h2;

   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   reg rst_m_q, rst_q;
   wire rst_n = rst_q;
   always @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rst_m_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_q <= rst_m_q;
      end
   end

   // asynchronous pins pass two flops; first stage read only by second
   reg [3:0] sync1_q, sync2_q;
   always @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else if (I_CE) begin
         sync1_q <= {I_XTAL_CLK, I_BAT_LOW, I_BAT_PRESENT, I_MAIN_BROWNOUT};
         sync2_q <= sync1_q;
      end
   end
   wire main_low = sync2_q[0];
   wire bat_ok = sync2_q[1];
   wire bat_low = sync2_q[2];
   wire xtal = sync2_q[3];

   // ----------------------------------------
   // supply switching
   // ----------------------------------------
   // control inputs are gated from the first synchronised sign of a
   // brownout until one cycle after it has gone, so a half-applied write
   // can never land while the supply is moving
   reg main_low_q, bat_ok_q;
   reg [1:0] boot_q;
   reg [2:0] stretch_q;
   wire switching = (main_low != main_low_q);
   wire gate = main_low | main_low_q;       // control inputs ignored while on battery
   wire acc = ~gate & O_ACCESS_EN;          // gated register access
   wire sup = ~gate;                        // supervision flags need no access enable, only main power
   always @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         main_low_q <= 1'b0;
         bat_ok_q <= 1'b0;
         boot_q <= 2'h0;
         stretch_q <= 3'h0;
         O_ON_BATTERY <= 1'b0;
         O_BAT_MONITOR_EN <= 1'b0;
         O_MAIN_DOMAIN_RESET <= 1'b0;
         O_SUPPLY_SWITCH_CLOSED <= 1'b0;
         O_BAT_POWER_ON_FLAG <= 1'b0;
         O_BAT_ABSENT_FLAG <= 1'b0;
      end else if (I_CE) begin
         main_low_q <= main_low;
         bat_ok_q <= bat_ok;
         // the battery pin is only trustworthy once both sync stages hold it
         if (boot_q != 2'h3)
            boot_q <= boot_q + 2'h1;
         // hold the tick steady a few cycles around each switchover
         if (switching)
            stretch_q <= STRETCH[2:0];
         else if (stretch_q != 3'h0)
            stretch_q <= stretch_q - 3'h1;
         O_ON_BATTERY <= main_low;
         O_BAT_MONITOR_EN <= main_low;
         O_MAIN_DOMAIN_RESET <= main_low;
         // battery insertion opens the switch; it closes on the next ungated cycle in which access is set or already enabled
         if (bat_ok & ~bat_ok_q)
            O_SUPPLY_SWITCH_CLOSED <= 1'b0;
         else if (acc | (sup & I_ACCESS_SET))
            O_SUPPLY_SWITCH_CLOSED <= 1'b1;
         if (bat_ok & ~bat_ok_q & ~main_low)
            O_BAT_POWER_ON_FLAG <= 1'b1;
         else if (sup & I_CLR_BAT_POWER_ON)
            O_BAT_POWER_ON_FLAG <= 1'b0;
         if ((boot_q == BOOT_SAMPLE) & ~bat_ok)
            O_BAT_ABSENT_FLAG <= 1'b1;
         else if (sup & I_CLR_BAT_ABSENT)
            O_BAT_ABSENT_FLAG <= 1'b0;
      end
   end

   // ----------------------------------------
   // crystal edge detect, ready and failure monitor
   // ----------------------------------------
   reg xtal_q;
   reg [15:0] swing_q;
   // wide enough for the full default timeout at the system clock
   reg [23:0] idle_q;
   wire swing = xtal & ~xtal_q;
   wire dom_rst = sup & I_DOMAIN_RESET & ~I_OSC_ENABLE_SET & ~I_FAIL_MON_SET;
   always @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         xtal_q <= 1'b0;
         swing_q <= 16'h0000;
         idle_q <= 24'h000000;
         O_OSC_READY_FLAG <= 1'b0;
         O_OSC_FAIL_FLAG <= 1'b0;
      end else if (I_CE) begin
         xtal_q <= xtal;
         if (dom_rst | ~O_OSC_ENABLE) begin
            swing_q <= 16'h0000;
            O_OSC_READY_FLAG <= 1'b0;
         end else if (swing) begin
            swing_q <= sat_inc(swing_q);
            if (swing_q >= STARTUP_SWINGS - 1)
               O_OSC_READY_FLAG <= 1'b1;
         end
         // saturates rather than wraps, so a long stop never looks healthy again
         if (swing)
            idle_q <= 24'h000000;
         else if (idle_q != 24'hFFFFFF)
            idle_q <= idle_q + 24'h000001;
         // a gap of 64 swing periods counts as a stop; set wins over clear
         if (O_FAIL_MON_EN & O_OSC_READY_FLAG & (idle_q >= FAIL_CYCLES))
            O_OSC_FAIL_FLAG <= 1'b1;
         else if (dom_rst | (acc & I_CLR_OSC_FAIL))
            O_OSC_FAIL_FLAG <= 1'b0;
      end
   end

   // ----------------------------------------
   // configuration bits
   // ----------------------------------------
   // enables are sticky; a domain reset drops the oscillator and monitor enables, never access enable
   always @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         O_ACCESS_EN <= 1'b0;
         O_HIGH_DRIVE <= 1'b0;
         O_TICK_SEL <= 1'b0;
         O_OSC_ENABLE <= 1'b0;
         O_FAIL_MON_EN <= 1'b0;
      end else if (I_CE) begin
         if (sup & I_ACCESS_SET)
            O_ACCESS_EN <= 1'b1;
         if (dom_rst) begin
            O_HIGH_DRIVE <= 1'b0;
            O_TICK_SEL <= 1'b0;
            O_OSC_ENABLE <= 1'b0;
            O_FAIL_MON_EN <= 1'b0;
         end else if (acc) begin
            if (I_HIGH_DRIVE_WR)
               O_HIGH_DRIVE <= I_HIGH_DRIVE;
            if (I_TICK_SEL_WR & ~O_OSC_ENABLE)
               O_TICK_SEL <= I_TICK_SEL;
            if (I_OSC_ENABLE_SET)
               O_OSC_ENABLE <= 1'b1;
            if (I_FAIL_MON_SET)
               O_FAIL_MON_EN <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // prescaler, counter, battery sampling
   // ----------------------------------------
   reg [15:0] pre_q;
   wire [15:0] div = O_TICK_SEL ? DIV_1KHZ[15:0] : DIV_1HZ[15:0];
   wire wrap = swing & O_OSC_READY_FLAG & (pre_q >= div - 16'h0001);
   reg pend_q;
   // swallowed edge is replayed after the stretch, so no tick is lost
   // a domain reset drops any due tick, so no pulse escapes with the oscillator off
   wire fire = (wrap | pend_q) & (stretch_q == 3'h0) & ~switching & ~dom_rst;
   // fast ticks since the last battery sample; the slow tick samples every time
   reg [9:0] sec_q;
   wire sec_due = ~O_TICK_SEL | (sec_q == FAST_LAST[9:0]);
   always @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 16'h0000;
         pend_q <= 1'b0;
         sec_q <= 10'h000;
         O_TICK <= 1'b0;
         O_COUNTER <= 32'h00000000;
         O_BAT_SAMPLE <= 1'b0;
         O_BAT_BROWNOUT_FLAG <= 1'b0;
      end else if (I_CE) begin
         if (dom_rst)
            pre_q <= 16'h0000;
         else if (swing & O_OSC_READY_FLAG)
            pre_q <= wrap ? 16'h0000 : pre_q + 16'h0001;
         pend_q <= (wrap | pend_q) & ~fire & ~dom_rst;
         // count fast ticks so the battery is still sampled once a second
         if (dom_rst)
            sec_q <= 10'h000;
         else if (fire & O_TICK_SEL)
            sec_q <= sec_q + 10'h001;
         O_TICK <= fire;
         if (fire)
            O_COUNTER <= O_COUNTER + 32'h00000001;
         // sample the battery once per second on battery power only,
         // whichever tick rate has been selected
         O_BAT_SAMPLE <= fire & sec_due & O_BAT_MONITOR_EN;
         if (O_BAT_SAMPLE & bat_low)
            O_BAT_BROWNOUT_FLAG <= 1'b1;
         else if (sup & I_CLR_BAT_BROWNOUT)
            O_BAT_BROWNOUT_FLAG <= 1'b0;
      end
   end

   // ----------------------------------------
   // retained registers
   // ----------------------------------------
   // contents untouched by domain reset or supply loss
   always @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         O_BACKUP0 <= 8'h00;
         O_BACKUP1 <= 8'h00;
      end else if (I_CE & acc & I_BACKUP_WR) begin
         if (I_BACKUP_SEL)
            O_BACKUP1 <= I_BACKUP_DATA;
         else
            O_BACKUP0 <= I_BACKUP_DATA;
      end
   end
endmodule
`default_nettype wire

// *** bbd_monitor.sv ***
// assertion checker for the battery backup domain controller
`timescale 1ns/1ps
`default_nettype none
module bbd_monitor (
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   input wire logic I_CE,
   input wire logic I_MAIN_BROWNOUT,
   input wire logic I_DOMAIN_RESET,
   input wire logic I_OSC_ENABLE_SET,
   input wire logic I_FAIL_MON_SET,
   input wire logic O_ON_BATTERY,
   input wire logic O_SUPPLY_SWITCH_CLOSED,
   input wire logic O_BAT_MONITOR_EN,
   input wire logic O_BAT_SAMPLE,
   input wire logic O_MAIN_DOMAIN_RESET,
   input wire logic O_HIGH_DRIVE,
   input wire logic O_OSC_ENABLE,
   input wire logic O_FAIL_MON_EN,
   input wire logic O_TICK_SEL,
   input wire logic O_ACCESS_EN,
   input wire logic O_BAT_POWER_ON_FLAG,
   input wire logic O_OSC_READY_FLAG,
   input wire logic O_TICK,
   input wire logic [31:0] O_COUNTER,
   input wire logic [7:0] O_BACKUP0
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);
   // ----------------------------------------
   // supply switching and tick stretch
   // ----------------------------------------
   sequence s_bo_rise; $rose(I_MAIN_BROWNOUT) ##0 I_CE; endsequence
   sequence s_quiet; !O_TICK [*3]; endsequence
   a_switch_follows: assert property (s_bo_rise |-> ##[1:4] O_ON_BATTERY)
      else $error("supply did not move to battery");
   a_monitor_follow: assert property (O_BAT_MONITOR_EN == O_ON_BATTERY)
      else $error("battery monitor state wrong");
   a_outer_reset: assert property (O_MAIN_DOMAIN_RESET == O_ON_BATTERY)
      else $error("outer reset not tied to main loss");
   a_tick_stretch: assert property ($changed(O_ON_BATTERY) |-> s_quiet)
      else $error("tick during switchover");
   a_sample_battery: assert property (O_BAT_SAMPLE |-> O_ON_BATTERY && O_BAT_MONITOR_EN)
      else $error("battery sampled on main power");
   a_loss_frozen: assert property (O_ON_BATTERY && $past(O_ON_BATTERY) |->
      $stable({O_HIGH_DRIVE, O_TICK_SEL, O_OSC_ENABLE, O_BACKUP0}))
      else $error("configuration changed during main loss");
   // ----------------------------------------
   // configuration, ready and counter
   // ----------------------------------------
   a_access_gate: assert property (!O_ACCESS_EN |=> $stable(O_HIGH_DRIVE))
      else $error("write taken without access");
   a_sel_locked: assert property (O_OSC_ENABLE |=> !O_OSC_ENABLE || $stable(O_TICK_SEL))
      else $error("tick select changed while running");
   a_reset_clears: assert property (I_DOMAIN_RESET && !I_OSC_ENABLE_SET && !I_FAIL_MON_SET
      && I_CE && O_ACCESS_EN && !O_ON_BATTERY && !$past(I_MAIN_BROWNOUT, 2)
      |=> !O_OSC_ENABLE && !O_OSC_READY_FLAG
      && !O_TICK_SEL && !O_HIGH_DRIVE && !O_FAIL_MON_EN)
      else $error("domain reset left bits set");
   a_ready_needs_osc: assert property (O_OSC_READY_FLAG |-> O_OSC_ENABLE)
      else $error("ready without oscillator");
   a_tick_needs_osc: assert property (O_TICK |-> O_OSC_ENABLE)
      else $error("tick without oscillator");
   a_count_step: assert property ($changed(O_COUNTER) |-> O_COUNTER == $past(O_COUNTER) + 32'h1)
      else $error("counter did not step by one");
   a_pon_opens: assert property ($rose(O_BAT_POWER_ON_FLAG) |-> !O_SUPPLY_SWITCH_CLOSED)
      else $error("switch closed on battery power-up");
endmodule
bind bbd_ctrl bbd_monitor u_mon (.I_CLK_SYS, .I_RESETN, .I_CE, .I_MAIN_BROWNOUT, .I_DOMAIN_RESET,
   .I_OSC_ENABLE_SET, .I_FAIL_MON_SET, .O_ON_BATTERY, .O_SUPPLY_SWITCH_CLOSED, .O_BAT_MONITOR_EN,
   .O_BAT_SAMPLE, .O_MAIN_DOMAIN_RESET, .O_HIGH_DRIVE, .O_OSC_ENABLE, .O_FAIL_MON_EN, .O_TICK_SEL,
   .O_ACCESS_EN, .O_BAT_POWER_ON_FLAG, .O_OSC_READY_FLAG, .O_TICK, .O_COUNTER, .O_BACKUP0);
`default_nettype wire

// *** bbd_supply_model.sv ***
// model of the backup cell and the external crystal
`timescale 1ns/1ps
`default_nettype none
module bbd_supply_model (
   input wire logic i_run,
   input wire logic i_bat_on,
   input wire logic i_bat_low,
   output logic o_xtal,
   output logic o_bat_present,
   output logic o_bat_low
);
   // crystal swings, 48 ns period; a halted crystal sits low with no edges at all
   initial o_xtal = 1'b0;
   always #24 o_xtal = i_run ? !o_xtal : 1'b0;
   // cell sensing: a missing cell can never report low voltage
   assign o_bat_present = i_bat_on;
   assign o_bat_low = i_bat_on & i_bat_low;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the battery backup domain controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic bo = 1'b0;
   logic run = 1'b1;
   logic bat_on = 1'b0;
   logic bat_low = 1'b0;
   logic [14:0] ctl = 15'h0000;
   logic [7:0] bkdat = 8'h00;
   logic xtal, bat_p, bat_l, on_bat, sw_cl, mon_en, mrst, hd, osc, fmon, sel, acc, tick;
   logic f_pon, f_bbo, f_abs, f_rdy, f_fail;
   logic [31:0] cnt;
   logic [31:0] c0;
   logic [7:0] bk0, bk1;
   logic [4:0] cfg;
   int n_errors = 0;
   int n_tests = 0;
   int g;
   // rows: control pulses {ce_off, bk_sel, bk_wr, clr x4, sel, sel_wr, hd, hd_wr, fmon, osc, acc,
   // dres}, then {acc, hd, sel, fmon, osc} expected afterwards
   logic [19:0] rows [12] = '{{15'h0030, 5'h00}, {15'h0002, 5'h10}, {15'h0030, 5'h18},
      {15'h00C0, 5'h1C}, {15'h0008, 5'h1E}, {15'h4010, 5'h1E}, {15'h0004, 5'h1F},
      {15'h0040, 5'h1F}, {15'h0005, 5'h1F}, {15'h0001, 5'h10}, {15'h00C0, 5'h14},
      {15'h0004, 5'h15}};
   assign cfg = {acc, hd, sel, fmon, osc};
   always #4 clk = !clk;
   bbd_supply_model u_cell (.i_run(run), .i_bat_on(bat_on), .i_bat_low(bat_low), .o_xtal(xtal),
      .o_bat_present(bat_p), .o_bat_low(bat_l));
   bbd_ctrl #(.FAIL_CYCLES(50), .DIV_1HZ(8), .DIV_1KHZ(32), .STARTUP_SWINGS(4)) dut (
      .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_CE(!ctl[14]), .I_MAIN_BROWNOUT(bo),
      .I_BAT_PRESENT(bat_p), .I_BAT_LOW(bat_l), .I_XTAL_CLK(xtal), .I_DOMAIN_RESET(ctl[0]),
      .I_ACCESS_SET(ctl[1]), .I_OSC_ENABLE_SET(ctl[2]), .I_FAIL_MON_SET(ctl[3]),
      .I_HIGH_DRIVE_WR(ctl[4]), .I_HIGH_DRIVE(ctl[5]), .I_TICK_SEL_WR(ctl[6]),
      .I_TICK_SEL(ctl[7]), .I_CLR_BAT_ABSENT(ctl[8]), .I_CLR_BAT_BROWNOUT(ctl[9]),
      .I_CLR_BAT_POWER_ON(ctl[10]), .I_CLR_OSC_FAIL(ctl[11]), .I_BACKUP_WR(ctl[12]),
      .I_BACKUP_SEL(ctl[13]), .I_BACKUP_DATA(bkdat), .O_ON_BATTERY(on_bat),
      .O_SUPPLY_SWITCH_CLOSED(sw_cl), .O_BAT_MONITOR_EN(mon_en), .O_BAT_SAMPLE(),
      .O_MAIN_DOMAIN_RESET(mrst), .O_HIGH_DRIVE(hd), .O_OSC_ENABLE(osc), .O_FAIL_MON_EN(fmon),
      .O_TICK_SEL(sel), .O_ACCESS_EN(acc), .O_BAT_POWER_ON_FLAG(f_pon),
      .O_BAT_BROWNOUT_FLAG(f_bbo), .O_BAT_ABSENT_FLAG(f_abs), .O_OSC_READY_FLAG(f_rdy),
      .O_OSC_FAIL_FLAG(f_fail), .O_TICK(tick), .O_COUNTER(cnt), .O_BACKUP0(bk0),
      .O_BACKUP1(bk1));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   // compare and count; four-state compare so an unknown never matches
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle control pulse, then time for the registered outputs to settle
   task apply(input logic [14:0] v);
      @(posedge clk) ctl <= v;
      @(posedge clk) ctl <= 15'h0000;
      repeat (3) @(posedge clk);
   endtask
   // sample on the falling edge so a one-cycle tick is seen settled
   task tick_gap(output int gap);
      repeat (2000) @(negedge clk) if (tick === 1'b1) break;
      gap = 0;
      do begin
         @(negedge clk);
         gap++;
      end while (tick !== 1'b1 && gap < 2000);
   endtask
   task wait_ready();
      repeat (400) @(negedge clk) if (f_rdy === 1'b1) break;
      @(posedge clk);
   endtask
   task print_verdict();
      $display("errors %0d of %0d comparisons", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      check(f_abs, 1);
      bat_on <= 1'b1;
      repeat (12) @(posedge clk);
      check({f_pon, sw_cl}, 2'b10);
      apply(15'h0500);
      check({f_abs, f_pon}, 0);
      foreach (rows[i]) begin
         apply(rows[i][19:5]);
         check(cfg, rows[i][4:0]);
      end
      check(sw_cl, 1);
      wait_ready();
      check(f_rdy, 1);
      tick_gap(g);
      check(g, 192);
      apply(15'h0001);
      check(f_rdy, 0);
      apply(15'h000C);
      wait_ready();
      tick_gap(g);
      check(g, 48);
      // crystal stops: no flag before the missed-swing window has run out
      run <= 1'b0;
      repeat (30) @(posedge clk);
      check(f_fail, 0);
      repeat (50) @(posedge clk);
      check(f_fail, 1);
      run <= 1'b1;
      // let swings resume first: a live failure condition would win over the clear
      repeat (8) @(posedge clk);
      apply(15'h0800);
      check(f_fail, 0);
      bkdat <= 8'hA5;
      apply(15'h1000);
      bkdat <= 8'h3C;
      apply(15'h3000);
      // main loss with a weak cell: writes refused, counting carries on
      bat_low <= 1'b1;
      bo <= 1'b1;
      repeat (8) @(posedge clk);
      check({on_bat, mon_en, mrst}, 3'b111);
      c0 = cnt;
      apply(15'h0031);
      check(cfg, 5'h13);
      repeat (200) @(posedge clk);
      check(cnt - c0 > 1, 1);
      check(f_bbo, 1);
      check({bk0, bk1}, 16'hA53C);
      bo <= 1'b0;
      repeat (8) @(posedge clk);
      check({on_bat, mon_en, mrst}, 0);
      check(f_abs, 0);
      check(f_fail, 0);
      check(f_bbo, 1);
      // second reset with the cell fitted: no absent flag, configuration lost
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      check(f_abs, 0);
      check(cfg, 0);
      check(cnt, 0);
      print_verdict();
   end
   // watchdog: the sequence needs a few thousand cycles at most
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
